// >>> pkg/pointer_regs_pkg.sv
// Constants for the pointer position and line count register block.
// Assumes a single 25 MHz ref_clk and a plain strobe register port.
package pointer_regs_pkg;
	localparam logic [15:0] OFS_HORIZ = 16'h8350;
	localparam logic [15:0] OFS_LINE  = 16'h8354;
	localparam logic [15:0] OFS_VERT  = 16'h8358;
	localparam logic [15:0] OFS_SPLIT = 16'h835C;
	localparam logic [15:0] OFS_CTRL  = 16'h8340;
	localparam int OFFSET_HI = 15;
	localparam int OFFSET_LO = 11;
	localparam int HPOS_HI   = 10;
	localparam int VPOS_HI   = 9;
	localparam int LINE_HI   = 10;
	localparam int PATTERN_SIZE = 32;
	localparam logic [31:0] RESET_REG = 32'h0000_0000;
	localparam logic [31:0] HORIZ_MASK = 32'h0000_FFFF;
	localparam logic [31:0] VERT_MASK  = 32'h0000_FBFF;
	localparam logic [31:0] SPLIT_MASK = 32'h0000_07FF;
	localparam logic [31:0] CTRL_MASK  = 32'h0000_0003;
	localparam int CTRL_PTR_EN  = 0;
	localparam int CTRL_CMP_EN  = 1;
endpackage

// >>> logic/pointer_match.sv
// Pointer hit detection for one scan position.
// Assumes coordinates already latched at frame start.
`timescale 1ns/100ps
`default_nettype none
module pointer_match #(
	parameter int PAT = 32
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Scan position
	input  wire logic [10:0] col,
	input  wire logic [10:0] line,
	input  wire logic        enable,
	// Programmed pointer
	input  wire logic [10:0] ptr_x,
	input  wire logic [9:0]  ptr_y,
	input  wire logic [4:0]  off_x,
	input  wire logic [4:0]  off_y,
	// Result
	output logic             hit,
	output logic [4:0]       pat_col,
	output logic [4:0]       pat_row
);
	logic [11:0] dx;
	logic [11:0] dy;
	always_comb begin
		dx = {1'b0, col} - {1'b0, ptr_x} + {7'h00, off_x};
		dy = {1'b0, line} - {2'h0, ptr_y} + {7'h00, off_y};
	end
	// Origin at upper-left; offsets skip leading rows and columns
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hit <= 1'b0;
			pat_col <= 5'h00;
			pat_row <= 5'h00;
		end else begin
			hit <= enable && col >= ptr_x && line >= {1'b0, ptr_y}
				&& dx < 12'(PAT) && dy < 12'(PAT);
			pat_col <= dx[4:0];
			pat_row <= dy[4:0];
		end
	end
endmodule
`default_nettype wire

// >>> logic/scan_counter.sv
// Horizontal and vertical scan counters for the raster.
// Assumes one pixel per ref_clk cycle.
`timescale 1ns/100ps
`default_nettype none
module scan_counter #(
	parameter int H_TOTAL = 800,
	parameter int V_TOTAL = 525
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Counts
	output logic [10:0]      col,
	output logic [10:0]      line,
	output logic             frame_start
);
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			col <= 11'h000;
			line <= 11'h000;
			frame_start <= 1'b0;
		end else begin
			frame_start <= 1'b0;
			if (col == 11'(H_TOTAL - 1)) begin
				col <= 11'h000;
				if (line == 11'(V_TOTAL - 1)) begin
					line <= 11'h000;
					frame_start <= 1'b1;
				end else begin
					line <= line + 11'h001;
				end
			end else begin
				col <= col + 11'h001;
			end
		end
	end
endmodule
`default_nettype wire

// >>> logic/pointer_position_regs.sv
// Pointer position, line count and split compare register block.
// Assumes ref_clk is also the pixel clock; strobes are single cycle.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module pointer_position_regs #(
	parameter int H_TOTAL = 800,
	parameter int V_TOTAL = 525
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [15:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	// Display timing outputs
	output logic             pointer_hit,
	output logic [4:0]       pattern_col,
	output logic [4:0]       pattern_row,
	output logic             start_offset_load,
	output logic             lower_region,
	output logic [10:0]      current_scanline
);
	logic [31:0] horiz;
	logic [31:0] vert;
	logic [31:0] split;
	logic [31:0] ctrl;
	logic [10:0] lat_x;
	logic [9:0]  lat_y;
	logic [4:0]  lat_ox;
	logic [4:0]  lat_oy;
	logic        lat_en;
	logic [10:0] col;
	logic [10:0] line;
	logic        frame_start;
	logic        hit;
	logic [4:0]  pcol;
	logic [4:0]  prow;

	// ----------------------------------------
	// Raster counters
	// ----------------------------------------
	scan_counter #(.H_TOTAL(H_TOTAL), .V_TOTAL(V_TOTAL)) u_scan (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.col        (col),
		.line       (line),
		.frame_start(frame_start)
	);

	// Cycles since the last frame start, for the raster checks
	logic [19:0] frame_len;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			frame_len <= 20'h00000;
		end else if (frame_start) begin
			frame_len <= 20'h00001;
		end else begin
			frame_len <= frame_len + 20'h00001;
		end
	end

	AST_FRAME_LEN: assert property (@(posedge ref_clk) disable iff (rst)
		frame_start |-> frame_len == 20'(H_TOTAL * V_TOTAL))
		else $error("frame length wrong");
	AST_COL_STEP: assert property (@(posedge ref_clk) disable iff (rst)
		!rst && col != 11'(H_TOTAL - 1)
		|=> col == $past(col) + 11'h001)
		else $error("column did not advance");
	AST_SCAN_SPAN: assert property (@(posedge ref_clk) disable iff (rst)
		col <= 11'(H_TOTAL - 1) && line <= 11'(V_TOTAL - 1))
		else $error("raster position out of range");

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			horiz <= pointer_regs_pkg::RESET_REG;
		end else if (wr && addr == pointer_regs_pkg::OFS_HORIZ) begin
			horiz <= wdata & pointer_regs_pkg::HORIZ_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			vert <= pointer_regs_pkg::RESET_REG;
		end else if (wr && addr == pointer_regs_pkg::OFS_VERT) begin
			vert <= wdata & pointer_regs_pkg::VERT_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			split <= pointer_regs_pkg::RESET_REG;
		end else if (wr && addr == pointer_regs_pkg::OFS_SPLIT) begin
			split <= wdata & pointer_regs_pkg::SPLIT_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl <= pointer_regs_pkg::RESET_REG;
		end else if (wr && addr == pointer_regs_pkg::OFS_CTRL) begin
			ctrl <= wdata & pointer_regs_pkg::CTRL_MASK;
		end
	end

	AST_HORIZ_RSVD: assert property (@(posedge ref_clk) disable iff (rst)
		horiz[31:16] == 16'h0000)
		else $error("horizontal reserved bits set");
	AST_HORIZ_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
		!(wr && addr == pointer_regs_pkg::OFS_HORIZ) |=> $stable(horiz))
		else $error("horizontal changed without write");
	AST_VERT_WR: assert property (@(posedge ref_clk) disable iff (rst)
		wr && addr == pointer_regs_pkg::OFS_VERT
		|=> vert == ($past(wdata) & pointer_regs_pkg::VERT_MASK))
		else $error("vertical write lost");
	AST_VERT_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
		!(wr && addr == pointer_regs_pkg::OFS_VERT) |=> $stable(vert))
		else $error("vertical changed without write");
	AST_SPLIT_WR: assert property (@(posedge ref_clk) disable iff (rst)
		wr && addr == pointer_regs_pkg::OFS_SPLIT
		|=> split == ($past(wdata) & pointer_regs_pkg::SPLIT_MASK))
		else $error("split write lost");
	AST_SPLIT_RSVD: assert property (@(posedge ref_clk) disable iff (rst)
		split[31:11] == 21'h00000)
		else $error("split reserved bits set");
	AST_CTRL_WR: assert property (@(posedge ref_clk) disable iff (rst)
		wr && addr == pointer_regs_pkg::OFS_CTRL
		|=> ctrl == ($past(wdata) & pointer_regs_pkg::CTRL_MASK))
		else $error("control write lost");

	// ----------------------------------------
	// Frame-start latch of coordinates, pattern offsets and pointer enable
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lat_x <= 11'h000;
			lat_y <= 10'h000;
		end else if (frame_start) begin
			lat_x <= horiz[pointer_regs_pkg::HPOS_HI:0];
			lat_y <= vert[pointer_regs_pkg::VPOS_HI:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lat_ox <= 5'h00;
			lat_oy <= 5'h00;
		end else if (frame_start) begin
			lat_ox <= horiz[pointer_regs_pkg::OFFSET_HI:pointer_regs_pkg::OFFSET_LO];
			lat_oy <= vert[pointer_regs_pkg::OFFSET_HI:pointer_regs_pkg::OFFSET_LO];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lat_en <= 1'b0;
		end else if (frame_start) begin
			lat_en <= ctrl[pointer_regs_pkg::CTRL_PTR_EN];
		end
	end

	AST_OFS_TAKE: assert property (@(posedge ref_clk) disable iff (rst)
		frame_start |=> lat_ox == $past(horiz[15:11])
		&& lat_oy == $past(vert[15:11]))
		else $error("pattern offsets not latched");
	AST_OFS_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
		!frame_start |=> $stable(lat_ox) && $stable(lat_oy)
		&& $stable(lat_en))
		else $error("offsets or enable changed mid frame");
	AST_EN_TAKE: assert property (@(posedge ref_clk) disable iff (rst)
		frame_start |=> lat_en == $past(ctrl[0]))
		else $error("pointer enable not latched");

	pointer_match #(.PAT(pointer_regs_pkg::PATTERN_SIZE)) u_match (
		.ref_clk(ref_clk),
		.rst    (rst),
		.col    (col),
		.line   (line),
		.enable (lat_en),
		.ptr_x  (lat_x),
		.ptr_y  (lat_y),
		.off_x  (lat_ox),
		.off_y  (lat_oy),
		.hit    (hit),
		.pat_col(pcol),
		.pat_row(prow)
	);

	// ----------------------------------------
	// Display outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pointer_hit <= 1'b0;
		end else begin
			pointer_hit <= hit;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pattern_col <= 5'h00;
		end else begin
			pattern_col <= pcol;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pattern_row <= 5'h00;
		end else begin
			pattern_row <= prow;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			current_scanline <= 11'h000;
		end else begin
			current_scanline <= line;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			start_offset_load <= 1'b0;
		end else begin
			start_offset_load <= ctrl[pointer_regs_pkg::CTRL_CMP_EN]
				&& col == 11'h000 && line == {1'b0, vert[9:0]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lower_region <= 1'b0;
		end else begin
			lower_region <= line >= split[10:0];
		end
	end

	AST_HIT_PIPE: assert property (@(posedge ref_clk) disable iff (rst)
		!rst |=> pointer_hit == $past(hit) && pattern_col == $past(pcol)
		&& pattern_row == $past(prow))
		else $error("pointer outputs not one cycle behind");
	AST_SCAN_OUT: assert property (@(posedge ref_clk) disable iff (rst)
		!rst |=> current_scanline == $past(line))
		else $error("scanline output lags wrongly");
	AST_LOAD_COL: assert property (@(posedge ref_clk) disable iff (rst)
		start_offset_load |-> $past(col) == 11'h000)
		else $error("start offset load away from column zero");
	AST_LOAD_ONE: assert property (@(posedge ref_clk) disable iff (rst)
		start_offset_load |=> !start_offset_load)
		else $error("start offset load longer than a cycle");

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			if (addr == pointer_regs_pkg::OFS_HORIZ) begin
				rdata <= horiz;
			end else if (addr == pointer_regs_pkg::OFS_LINE) begin
				rdata <= {21'h000000, line};
			end else if (addr == pointer_regs_pkg::OFS_VERT) begin
				rdata <= vert;
			end else if (addr == pointer_regs_pkg::OFS_SPLIT) begin
				rdata <= split;
			end else if (addr == pointer_regs_pkg::OFS_CTRL) begin
				rdata <= ctrl;
			end else begin
				rdata <= 32'h0000_0000;
			end
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	AST_RD_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
		!rd |=> rdata == 32'h0000_0000)
		else $error("read data not cleared");
	AST_RD_HORIZ: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == pointer_regs_pkg::OFS_HORIZ |=> rdata == $past(horiz))
		else $error("horizontal read wrong");
	AST_RD_VERT: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == pointer_regs_pkg::OFS_VERT |=> rdata == $past(vert))
		else $error("vertical read wrong");
	AST_RD_SPLIT: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == pointer_regs_pkg::OFS_SPLIT |=> rdata == $past(split))
		else $error("split read wrong");
	AST_RD_CTRL: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == pointer_regs_pkg::OFS_CTRL |=> rdata == $past(ctrl))
		else $error("control read wrong");
	AST_RD_NONE: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr != pointer_regs_pkg::OFS_HORIZ
		&& addr != pointer_regs_pkg::OFS_LINE
		&& addr != pointer_regs_pkg::OFS_VERT
		&& addr != pointer_regs_pkg::OFS_SPLIT
		&& addr != pointer_regs_pkg::OFS_CTRL |=> rdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_LINE_READ: assert property (@(posedge ref_clk) disable iff (rst)
		rd && addr == pointer_regs_pkg::OFS_LINE |=> rdata[31:11] == 21'h0
		&& rdata[10:0] == $past(line))
		else $error("line count read wrong");
	AST_VERT_RSVD: assert property (@(posedge ref_clk) disable iff (rst)
		vert[10] == 1'b0 && vert[31:16] == 16'h0000)
		else $error("vertical reserved bits set");
	AST_HORIZ_WR: assert property (@(posedge ref_clk) disable iff (rst)
		wr && addr == pointer_regs_pkg::OFS_HORIZ |=> horiz[15:0] == $past(wdata[15:0]))
		else $error("horizontal write lost");
	AST_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
		!frame_start |=> $stable(lat_x) && $stable(lat_y))
		else $error("coordinates changed mid frame");
	AST_LATCH_TAKE: assert property (@(posedge ref_clk) disable iff (rst)
		frame_start |=> lat_x == $past(horiz[10:0]) && lat_y == $past(vert[9:0]))
		else $error("coordinates not latched");
	AST_LINE_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
		frame_start |-> line == 11'h000 && col == 11'h000)
		else $error("frame start not at line zero");
	AST_LINE_STEP: assert property (@(posedge ref_clk) disable iff (rst)
		col == 11'(H_TOTAL - 1) && line != 11'(V_TOTAL - 1) |=> line == $past(line) + 11'h001)
		else $error("line did not advance");
	AST_HIT_POS: assert property (@(posedge ref_clk) disable iff (rst)
		hit |-> $past(lat_en) && $past(col) >= $past(lat_x))
		else $error("pointer hit left of position");
	AST_HIT_ROW: assert property (@(posedge ref_clk) disable iff (rst)
		hit |-> $past(line) >= {1'b0, $past(lat_y)})
		else $error("pointer hit above position");
	AST_COMPARE: assert property (@(posedge ref_clk) disable iff (rst)
		start_offset_load |-> $past(ctrl[1]) && $past(line) == {1'b0, $past(vert[9:0])})
		else $error("start offset load at wrong line");
	AST_SPLIT: assert property (@(posedge ref_clk) disable iff (rst)
		!rst |=> lower_region == ($past(line) >= $past(split[10:0])))
		else $error("lower region wrong");
	COV_HIT: cover property (@(posedge ref_clk) pointer_hit);
	COV_LOAD: cover property (@(posedge ref_clk) start_offset_load);
	COV_FRAME: cover property (@(posedge ref_clk) frame_start);
	COV_READ: cover property (@(posedge ref_clk) rd && addr == pointer_regs_pkg::OFS_LINE);
endmodule
`default_nettype wire

// >>> tb/test_pointer_position_regs.sv
// Self-checking bench for the pointer position register block.
// Assumes a short raster (40 x 10) so that frames stay brief.
`timescale 1ns/100ps
`default_nettype none
module test_pointer_position_regs;
	localparam int HT = 40;
	localparam int VT = 10;
	logic        ref_clk = 1'b0;
	logic        rst     = 1'b1;
	logic [15:0] addr    = 16'h0000;
	logic [31:0] wdata   = 32'h0000_0000;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic [31:0] rdata;
	logic        pointer_hit;
	logic [4:0]  pattern_col;
	logic [4:0]  pattern_row;
	logic        start_offset_load;
	logic        lower_region;
	logic [10:0] current_scanline;
	int          err_total = 0;
	int          compares  = 0;
	int          cyc       = 0;

	pointer_position_regs #(.H_TOTAL(HT), .V_TOTAL(VT)) dut_u (
		.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .pointer_hit(pointer_hit),
		.pattern_col(pattern_col), .pattern_row(pattern_row),
		.start_offset_load(start_offset_load),
		.lower_region(lower_region), .current_scanline(current_scanline)
	);

	// ------------------------------------------------------------
	// Clock, timeout and report
	// ------------------------------------------------------------
	always #20 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		if (err_total == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr    <= 1'b0;
	endtask

	task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask

	// Counts display outputs over exactly one frame
	task automatic frame(output int hits, loads, lows,
		output logic [4:0] c0, r0);
		int i;
		hits  = 0;
		loads = 0;
		lows  = 0;
		do begin
			@(posedge ref_clk);
			#1;
		end while (current_scanline !== 11'(VT - 1));
		do begin
			@(posedge ref_clk);
			#1;
		end while (current_scanline !== 11'h000);
		for (i = 0; i < HT * VT; i++) begin
			@(posedge ref_clk);
			#1;
			if (pointer_hit === 1'b1) begin
				if (hits == 0) begin
					c0 = pattern_col;
					r0 = pattern_row;
				end
				hits++;
			end
			if (start_offset_load === 1'b1)
				loads++;
			if (lower_region === 1'b1)
				lows++;
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [31:0] prev;
		logic [4:0]  pc;
		logic [4:0]  pr;
		int          h;
		int          ld;
		int          lw;
		int          wraps;
		int          hx[4] = '{32'h0005, 32'h8005, 32'h0000, 32'h0005};
		int          vy[4] = '{32'h0002, 32'hE002, 32'h0000, 32'h0002};
		int          en[4] = '{1, 1, 1, 0};
		int          eh[4] = '{256, 64, 320, 0};
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		rd_reg(pointer_regs_pkg::OFS_HORIZ, d);
		check("horiz reset", d, 32'h0000_0000);
		rd_reg(pointer_regs_pkg::OFS_VERT, d);
		check("vert reset", d, 32'h0000_0000);
		// Reserved bits and unmapped places
		wr_reg(pointer_regs_pkg::OFS_HORIZ, 32'hFFFF_FFFF);
		rd_reg(pointer_regs_pkg::OFS_HORIZ, d);
		check("horiz mask", d, 32'h0000_FFFF);
		wr_reg(pointer_regs_pkg::OFS_VERT, 32'hFFFF_FFFF);
		rd_reg(pointer_regs_pkg::OFS_VERT, d);
		check("vert mask", d, 32'h0000_FBFF);
		wr_reg(pointer_regs_pkg::OFS_SPLIT, 32'hFFFF_FFFF);
		rd_reg(pointer_regs_pkg::OFS_SPLIT, d);
		check("split mask", d, 32'h0000_07FF);
		wr_reg(16'h8364, 32'hFFFF_FFFF);
		rd_reg(16'h8364, d);
		check("unmapped", d, 32'h0000_0000);
		// Line count read repeatedly across frames
		wr_reg(pointer_regs_pkg::OFS_LINE, 32'hFFFF_FFFF);
		rd_reg(pointer_regs_pkg::OFS_LINE, prev);
		wraps = 0;
		repeat (600) begin
			rd_reg(pointer_regs_pkg::OFS_LINE, d);
			check("line upper", {11'h000, d[31:11]}, 32'h0000_0000);
			check("scanline out", {21'h00000, current_scanline}, d);
			check("line step", {31'h0, d < VT && (d == prev || d == prev + 1
				|| (prev == VT - 1 && d == 0))}, 32'h0000_0001);
			if (prev == VT - 1 && d == 0)
				wraps++;
			prev = d;
		end
		check("line wraps", {31'h0, wraps > 0}, 32'h0000_0001);
		// Pointer placement and pattern offsets
		for (int i = 0; i < 4; i++) begin
			wr_reg(pointer_regs_pkg::OFS_HORIZ, hx[i]);
			wr_reg(pointer_regs_pkg::OFS_VERT, vy[i]);
			wr_reg(pointer_regs_pkg::OFS_CTRL, en[i]);
			repeat (2 * HT * VT) @(posedge ref_clk);
			frame(h, ld, lw, pc, pr);
			check("hit count", h, eh[i]);
			if (eh[i] > 0) begin
				check("first col", pc, hx[i][15:11]);
				check("first row", pr, vy[i][15:11]);
			end
		end
		// Line compare with the pointer off, and the split line
		wr_reg(pointer_regs_pkg::OFS_CTRL, 32'h0000_0002);
		wr_reg(pointer_regs_pkg::OFS_VERT, 32'h0000_0003);
		wr_reg(pointer_regs_pkg::OFS_SPLIT, 32'h0000_0006);
		repeat (2 * HT * VT) @(posedge ref_clk);
		frame(h, ld, lw, pc, pr);
		check("compare pulses", ld, 1);
		check("lower cycles", lw, (VT - 6) * HT);
		check("hits off", h, 0);
		final_report();
	end
endmodule
`default_nettype wire
